// ===== hdl/svipq_defs.svh
// timing counts, offsets and reset values of the servo input qualifier
`ifndef SVIPQ_DEFS_SVH
`define SVIPQ_DEFS_SVH
`define SVIPQ_CLK_NS 100
`define SVIPQ_DOWN(t) ((t) / `SVIPQ_CLK_NS)
`define SVIPQ_UP(t) (((t) + `SVIPQ_CLK_NS - 1) / `SVIPQ_CLK_NS)
`define SVIPQ_SAMP0_NS 166000
`define SVIPQ_SAMP1_NS 333000
`define SVIPQ_SAMP2_NS 1000000
`define SVIPQ_SAMP3_NS 1666000
`define SVIPQ_MS_NS 1000000
`define SVIPQ_CLR100_NS 100000
`define SVIPQ_CLR500_NS 500000
`define SVIPQ_CLR1M_NS 1000000
`define SVIPQ_RST_CONFIRM_MS 7'h78
`define SVIPQ_STOP_SPEED 15'h001E
`define SVIPQ_OVERLOAD_MAX 10'h073
`define SVIPQ_TORQUE_SCALE 4'hA
`define SVIPQ_FILTER_N 3
`define SVIPQ_REG_STATUS 4'h0
`define SVIPQ_REG_PULSES 4'h4
`define SVIPQ_REG_CTRL 4'h8
`define SVIPQ_REG_TORQUE 4'hC
`define SVIPQ_CTRL_CLR_BIT 0
`define SVIPQ_CTRL_RST_BIT 1
`define SVIPQ_DEF_OVERRUN 10'h00A
`define SVIPQ_DEF_CLR_MODE 3'h3
`define SVIPQ_DEF_INHIBIT_EN 1'h1
`define SVIPQ_DEF_DETECT_MS 11'h0C8
`endif

// ===== hdl/svipq_filter.sv
// consecutive-match filter for sampled control inputs
`timescale 1ns/1ns
module svipq_filter #(
    parameter int W = 6,
    parameter int N = 3
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // samples
    input  wire logic         sampleEn,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0][N-1:0] hist;
        logic [W-1:0]        level;
    } svipq_flt_t;

    svipq_flt_t s;
    svipq_flt_t next_s;

    if (N < 2 || W < 1) begin : g_bad
        $error("svipq_filter: N must be at least 2");
    end

    always_comb begin
        next_s = s;
        if (sampleEn) begin
            for (int i = 0; i < W; i++) begin
                next_s.hist[i] = {s.hist[i][N-2:0], raw[i]};
                if (&next_s.hist[i]) begin
                    next_s.level[i] = 1'b1;
                end else if (~|next_s.hist[i]) begin
                    next_s.level[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

    a_filter_rise: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.level[0]) |-> (&s.hist[0]) && $past(sampleEn))
        else $error("input bit 0 accepted without matching samples");
endmodule // svipq_filter

// ===== hdl/svipq_pkg.sv
// types of the servo input qualifier
package svipq_pkg;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_IMM   = 3'b001,
        ST_DECEL = 3'b010,
        ST_STOP  = 3'b011,
        ST_TRIP  = 3'b100
    } svipq_state_t;
    typedef enum logic [2:0] {
        AC_NONE = 3'b000,
        AC_OS1  = 3'b001,
        AC_OS2  = 3'b010,
        AC_OVLD = 3'b011,
        AC_ORUN = 3'b100,
        AC_EXT  = 3'b101
    } svipq_alarm_t;
    typedef struct packed {
        logic [9:0]  immStopTorque;
        logic [9:0]  overloadLevel;
        logic [14:0] overspeedLevel;
        logic [14:0] immStopOverspeedLevel;
        logic [9:0]  overrunLimit;
        logic [1:0]  inputSamplePeriodSel;
        logic        alarmResetConfirmSel;
        logic [2:0]  errCountClearMode;
        logic        pulseInhibitEnable;
        logic [10:0] alarmDetectAllowTime;
        logic [3:0]  driveProhibitStopSel;
        logic [3:0]  servoOffStopSel;
        logic [3:0]  mainPowerOffStopSel;
        logic [2:0]  alarmStopSel;
    } svipq_cfg_t;
    typedef struct packed {
        logic [14:0] speed;
        logic [14:0] maxSpeed;
        logic [9:0]  torque;
        logic [9:0]  normTorque;
        logic [9:0]  travel;
        logic        dpDecel;
        logic        soDecel;
        logic        mpDecel;
        logic        extNoImm;
        logic        extImm;
    } svipq_meas_t;
    typedef struct packed {
        svipq_state_t state;
        svipq_alarm_t alarmCode;
        logic [13:0]  torqueLimit;
        logic         immTorqueActive;
    } svipq_prot_t;
    typedef struct packed {
        svipq_cfg_t  cfg;
        logic        cfgLoaded;
        svipq_prot_t prot;
        logic [10:0] detTimer;
        logic [14:0] msCnt;
        logic [14:0] sampCnt;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic        rstPrev;
        logic [6:0]  confCnt;
        logic        swReset;
        logic [14:0] clrCnt;
        logic        clrArmed;
        logic        errClear;
        logic        pulsePrev;
        logic [15:0] pulseCnt;
        logic        ack;
        logic [31:0] readData;
    } svipq_main_t;
endpackage

// ===== hdl/svipq_top.sv
// input qualification and protective stop supervisor of a servo drive
`timescale 1ns/1ns
`include "svipq_defs.svh"
module svipq_top import svipq_pkg::*; #(
    parameter int SAMP0_CYC = `SVIPQ_DOWN(`SVIPQ_SAMP0_NS),
    parameter int SAMP1_CYC = `SVIPQ_DOWN(`SVIPQ_SAMP1_NS),
    parameter int SAMP2_CYC = `SVIPQ_DOWN(`SVIPQ_SAMP2_NS),
    parameter int SAMP3_CYC = `SVIPQ_DOWN(`SVIPQ_SAMP3_NS),
    parameter int MS_CYC    = `SVIPQ_DOWN(`SVIPQ_MS_NS),
    parameter int CLR1_CYC  = `SVIPQ_UP(`SVIPQ_CLR100_NS),
    parameter int CLR5_CYC  = `SVIPQ_UP(`SVIPQ_CLR500_NS),
    parameter int CLRM_CYC  = `SVIPQ_UP(`SVIPQ_CLR1M_NS),
    parameter int FILT_N    = `SVIPQ_FILTER_N
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // static settings and drive measurements
    input  wire svipq_cfg_t  cfgIn,
    input  wire svipq_meas_t meas,
    // control input pins
    input  wire logic [3:0]  genIn,
    input  wire logic        alarmResetIn,
    input  wire logic        pulseInhibitIn,
    input  wire logic        errClearIn,
    input  wire logic        cmdPulseIn,
    // results
    output svipq_prot_t      prot,
    output logic             errClear,
    output logic [15:0]      pulseCount,
    output logic [3:0]       genLevel
);
    localparam svipq_cfg_t CFG_DEF = '{
        overrunLimit:         `SVIPQ_DEF_OVERRUN,
        errCountClearMode:    `SVIPQ_DEF_CLR_MODE,
        pulseInhibitEnable:   `SVIPQ_DEF_INHIBIT_EN,
        alarmDetectAllowTime: `SVIPQ_DEF_DETECT_MS,
        default:              '0
    };

    if (SAMP3_CYC > 32767 || MS_CYC > 32767 || CLRM_CYC > 32767 ||
        SAMP0_CYC < 2 || MS_CYC < 2 || CLR1_CYC < 1) begin : g_bad
        $error("svipq_top: cycle counts outside 2..32767");
    end

    svipq_main_t s;
    svipq_main_t next_s;
    logic [5:0]  fLevel;
    logic        sampleTick;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [14:0] sampPeriod(input logic [1:0] sel);
        case (sel)
            2'h0:    return 15'(SAMP0_CYC - 1);
            2'h1:    return 15'(SAMP1_CYC - 1);
            2'h2:    return 15'(SAMP2_CYC - 1);
            default: return 15'(SAMP3_CYC - 1);
        endcase
    endfunction

    // zero or too large both mean 1.2 x maximum speed
    function automatic logic [15:0] osLimit(input logic [14:0] set,
                                            input logic [14:0] maxSpd);
        logic [17:0] lim;
        lim = ({3'h0, maxSpd} * 18'h00006) / 18'h00005;
        if (set == 15'h0000 || {3'h0, set} > lim) begin
            return lim[15:0];
        end
        return {1'b0, set};
    endfunction

    function automatic logic offSelImm(input logic [3:0] sel);
        return sel == 4'h8 || sel == 4'h9;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // qualified inputs

    svipq_filter #(
        .W (6),
        .N (FILT_N)
    ) u_filter (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .sampleEn (sampleTick),
        .raw      (s.sync2[5:0]),
        .level    (fLevel)
    );

    ////////////////////////////////////////////////////////////////////////
    // protection and qualification

    logic        os1;
    logic        os2;
    logic        ovl;
    logic        orun;
    logic        noImm;
    logic        immAl;
    logic        slow;
    logic        msTick;
    logic        resetHit;
    logic        inhibit;
    logic        clrRaw;
    logic        held;
    logic [14:0] clrMin;
    logic [9:0]  ovlLimit;
    svipq_alarm_t firstCode;

    always_comb begin
        next_s = s;
        next_s.sync1 = {cmdPulseIn, errClearIn, pulseInhibitIn, alarmResetIn, genIn};
        next_s.sync2 = s.sync1;
        if (!s.cfgLoaded) begin
            next_s.cfg = cfgIn;
            next_s.cfgLoaded = 1'b1;
        end

        sampleTick = s.sampCnt == 15'h0000;
        next_s.sampCnt = sampleTick ? sampPeriod(s.cfg.inputSamplePeriodSel)
                                    : s.sampCnt - 15'h0001;
        msTick = s.msCnt == 15'h0000;
        next_s.msCnt = msTick ? 15'(MS_CYC - 1) : s.msCnt - 15'h0001;

        // alarm detection
        ovlLimit = (s.cfg.overloadLevel == 10'h000 ||
                    s.cfg.overloadLevel > `SVIPQ_OVERLOAD_MAX)
                   ? `SVIPQ_OVERLOAD_MAX : s.cfg.overloadLevel;
        os1  = {1'b0, meas.speed} > osLimit(s.cfg.overspeedLevel, meas.maxSpeed);
        os2  = {1'b0, meas.speed} >
               osLimit(s.cfg.immStopOverspeedLevel, meas.maxSpeed);
        ovl  = meas.torque > ovlLimit;
        orun = meas.travel > s.cfg.overrunLimit;
        noImm = os2 || meas.extNoImm;
        immAl = os1 || ovl || orun || meas.extImm;
        slow  = meas.speed <= `SVIPQ_STOP_SPEED;
        // first-level code wins the display when both fire
        if (os1) begin
            firstCode = AC_OS1;
        end else if (os2) begin
            firstCode = AC_OS2;
        end else if (ovl) begin
            firstCode = AC_OVLD;
        end else if (orun) begin
            firstCode = AC_ORUN;
        end else begin
            firstCode = AC_EXT;
        end

        // alarm reset confirmation
        clrRaw = s.sync2[6];
        if (!s.sync2[4]) begin
            next_s.confCnt = 7'h00;
        end else if (msTick && s.confCnt != `SVIPQ_RST_CONFIRM_MS) begin
            next_s.confCnt = s.confCnt + 7'h01;
        end
        next_s.rstPrev = fLevel[4];
        if (s.cfg.alarmResetConfirmSel) begin
            resetHit = fLevel[4] && !s.rstPrev;
        end else begin
            resetHit = s.sync2[4] && msTick &&
                       s.confCnt == `SVIPQ_RST_CONFIRM_MS - 7'h01;
        end
        resetHit = resetHit || s.swReset;
        next_s.swReset = 1'b0;

        // state machine
        case (s.prot.state)
            ST_RUN: begin
                if (noImm) begin
                    next_s.prot.state = ST_TRIP;
                    next_s.prot.alarmCode = firstCode;
                end else if (immAl) begin
                    next_s.prot.alarmCode = firstCode;
                    next_s.detTimer = s.cfg.alarmDetectAllowTime;
                    next_s.prot.state = s.cfg.alarmStopSel[2] ? ST_IMM
                                                              : ST_DECEL;
                end
            end
            ST_IMM: begin
                if (noImm) begin
                    next_s.prot.state = ST_TRIP;
                end else if (slow) begin
                    next_s.prot.state = ST_STOP;
                end else if (s.detTimer == 11'h000) begin
                    next_s.prot.state = ST_TRIP;
                end else if (msTick) begin
                    next_s.detTimer = s.detTimer - 11'h001;
                end
            end
            ST_DECEL: begin
                if (slow) begin
                    next_s.prot.state = ST_STOP;
                end
            end
            ST_STOP, ST_TRIP: begin
                if (resetHit && !noImm && !immAl) begin
                    next_s.prot.state = ST_RUN;
                    next_s.prot.alarmCode = AC_NONE;
                end
            end
            default: begin
                next_s.prot.state = ST_RUN;
            end
        endcase

        // torque limit in 0.1 % of rated torque
        next_s.prot.immTorqueActive = s.prot.state == ST_IMM ||
            (meas.dpDecel && s.cfg.driveProhibitStopSel == 4'h2) ||
            (meas.mpDecel && offSelImm(s.cfg.mainPowerOffStopSel)) ||
            (meas.soDecel && offSelImm(s.cfg.servoOffStopSel));
        if (next_s.prot.immTorqueActive && s.cfg.immStopTorque != 10'h000) begin
            next_s.prot.torqueLimit = {4'h0, s.cfg.immStopTorque};
        end else begin
            next_s.prot.torqueLimit = 14'(meas.normTorque * `SVIPQ_TORQUE_SCALE);
        end

        // error counter clear; edge modes need an inactive spell first
        case (s.cfg.errCountClearMode)
            3'h1:    clrMin = 15'(CLR5_CYC);
            3'h3:    clrMin = 15'(CLR1_CYC);
            default: clrMin = 15'(CLRM_CYC);
        endcase
        held = clrRaw && s.clrCnt >= clrMin;
        if (!clrRaw) begin
            next_s.clrCnt = 15'h0000;
            next_s.clrArmed = 1'b1;
        end else if (s.clrCnt != 15'h7FFF) begin
            next_s.clrCnt = s.clrCnt + 15'h0001;
        end
        case (s.cfg.errCountClearMode)
            3'h1, 3'h2: begin
                next_s.errClear = held;
            end
            3'h3, 3'h4: begin
                next_s.errClear = held && s.clrArmed;
                if (held) begin
                    next_s.clrArmed = 1'b0;
                end
            end
            default: begin
                next_s.errClear = 1'b0;
            end
        endcase

        // command pulse counting
        inhibit = !s.cfg.pulseInhibitEnable && fLevel[5];
        next_s.pulsePrev = s.sync2[7];
        if (s.sync2[7] && !s.pulsePrev && !inhibit) begin
            next_s.pulseCnt = s.pulseCnt + 16'h0001;
        end

        // register bus: one wait cycle on every access
        next_s.ack = (avs_read || avs_write) && !s.ack;
        if (avs_read && !s.ack) begin
            case (avs_address)
                `SVIPQ_REG_STATUS: next_s.readData = {18'h00000, fLevel, 1'b0,
                    s.prot.alarmCode, 1'b0, s.prot.state};
                `SVIPQ_REG_PULSES: next_s.readData = {16'h0000, s.pulseCnt};
                `SVIPQ_REG_TORQUE: next_s.readData = {17'h00000,
                    s.prot.immTorqueActive, s.prot.torqueLimit};
                default:           next_s.readData = 32'h00000000;
            endcase
        end
        if (avs_write && s.ack && avs_address == `SVIPQ_REG_CTRL && avs_byteenable[0]) begin
            next_s.swReset = avs_writedata[`SVIPQ_CTRL_RST_BIT];
            if (avs_writedata[`SVIPQ_CTRL_CLR_BIT]) begin
                next_s.pulseCnt = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.cfg <= CFG_DEF;
        end else begin
            s <= next_s;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
    assign avs_readdata    = s.readData;
    assign prot            = s.prot;
    assign errClear        = s.errClear;
    assign pulseCount      = s.pulseCnt;
    assign genLevel        = fLevel[3:0];

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence seq_run_alarm;
        s.prot.state == ST_RUN && s.cfgLoaded;
    endsequence
    sequence seq_imm_overdue;
        s.prot.state == ST_IMM && s.detTimer == 11'h000 && !slow && !noImm;
    endsequence

    a_os2_direct_trip: assert property (seq_run_alarm and os2 |=>
        s.prot.state == ST_TRIP)
        else $error("second overspeed did not trip directly");
    a_both_os_code: assert property (seq_run_alarm and (os1 && os2) |=>
        s.prot.alarmCode == AC_OS1 && s.prot.state == ST_TRIP)
        else $error("dual overspeed code or trip wrong");
    a_imm_stop_enter: assert property (seq_run_alarm and (immAl && !noImm) |=>
        s.prot.state == (s.cfg.alarmStopSel[2] ? ST_IMM : ST_DECEL))
        else $error("alarm stop path wrong");
    a_imm_abort_trip: assert property (s.prot.state == ST_IMM && noImm |=>
        s.prot.state == ST_TRIP)
        else $error("non immediate-stop alarm did not abort");
    a_imm_timeout_trip: assert property (seq_imm_overdue |=>
        s.prot.state == ST_TRIP)
        else $error("immediate stop overdue without trip");
    a_torque_fallback: assert property (s.prot.immTorqueActive &&
        s.cfg.immStopTorque == 10'h000 |->
        s.prot.torqueLimit == 14'($past(meas.normTorque) * `SVIPQ_TORQUE_SCALE))
        else $error("zero immediate torque did not use normal limit");
    a_inhibit_holds: assert property (inhibit && !(avs_write && s.ack) |=>
        s.pulseCnt == $past(s.pulseCnt))
        else $error("pulses counted while inhibited");
    a_edge_clear_once: assert property (s.errClear &&
        s.cfg.errCountClearMode[2:1] != 2'b00 && s.cfg.errCountClearMode != 3'h2 |=>
        !s.errClear)
        else $error("edge clear longer than one cycle");
    a_level_clear_hold: assert property (s.cfg.errCountClearMode == 3'h1 &&
        clrRaw && s.clrCnt == 15'(CLR5_CYC) |=> s.errClear)
        else $error("level clear not raised after hold time");
endmodule // svipq_top

// ===== verification/svipq_host.sv
// host controller model that drives the control input pins of the qualifier
`timescale 1ns/1ns
module svipq_host (
    // clock
    input  wire logic       ref_clk,
    // control input pins
    output logic      [3:0] genIn,
    output logic            alarmResetIn,
    output logic            pulseInhibitIn,
    output logic            errClearIn,
    output logic            cmdPulseIn
);
    initial begin
        genIn = 4'h0;
        alarmResetIn = 1'h0;
        pulseInhibitIn = 1'h0;
        errClearIn = 1'h0;
        cmdPulseIn = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // two cycles high and low, so the pin synchroniser never drops an edge
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            cmdPulseIn <= 1'h1;
            repeat (2) @(posedge ref_clk);
            cmdPulseIn <= 1'h0;
            @(posedge ref_clk);
        end
    endtask
    task automatic clearHold(input int n);
        errClearIn <= 1'h1;
        repeat (n) @(posedge ref_clk);
        errClearIn <= 1'h0;
    endtask
endmodule // svipq_host

// ===== verification/test_svipq_top.sv
// self-checking bench of the servo input qualifier
`timescale 1ns/1ns
module test_svipq_top import svipq_pkg::*;;
    typedef struct packed {
        logic [14:0]  osl, iso, spd;
        logic [9:0]   ovl, trq, trv;
        logic [2:0]   sel;
        logic         nim;
        svipq_state_t st;
        svipq_alarm_t ac;
    } svipq_row_t;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, errClear;
    logic        alarmResetIn, pulseInhibitIn, errClearIn, cmdPulseIn;
    logic [3:0]  avs_address, avs_byteenable, genIn, genLevel;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] pulseCount;
    svipq_cfg_t  cfgIn, base, c;
    svipq_meas_t meas, mb, m;
    svipq_prot_t prot;
    svipq_row_t  r;
    int          nErrors = 0, checked = 0, k, n;
    // held cycles beyond the minimum width show up as cycles of level clear
    int          hold[5] = '{20, 5020, 10020, 1020, 10020};
    int          lo[5] = '{0, 18, 18, 1, 1};
    int          hi[5] = '{0, 22, 22, 1, 1};
    svipq_row_t  rows[11] = '{
        '{15'h1F4, 15'h190, 15'h1C2, 10'h0, 10'h0, 10'h0, 3'h0, 1'h0, ST_TRIP, AC_OS2},
        '{15'h1F4, 15'h190, 15'h258, 10'h0, 10'h0, 10'h0, 3'h0, 1'h0, ST_TRIP, AC_OS1},
        '{15'h1F4, 15'h0, 15'h258, 10'h0, 10'h0, 10'h0, 3'h4, 1'h0, ST_IMM, AC_OS1},
        '{15'h0, 15'h0, 15'h4B0, 10'h0, 10'h0, 10'h0, 3'h4, 1'h0, ST_RUN, AC_NONE},
        '{15'h0, 15'h0, 15'h4B1, 10'h0, 10'h0, 10'h0, 3'h4, 1'h0, ST_TRIP, AC_OS1},
        '{15'hBB8, 15'h0, 15'h4B1, 10'h0, 10'h0, 10'h0, 3'h4, 1'h0, ST_TRIP, AC_OS1},
        '{15'h0, 15'h0, 15'h64, 10'h0, 10'h74, 10'h0, 3'h0, 1'h0, ST_DECEL, AC_OVLD},
        '{15'h0, 15'h0, 15'h0, 10'h0, 10'h73, 10'h0, 3'h4, 1'h0, ST_RUN, AC_NONE},
        '{15'h0, 15'h0, 15'h64, 10'hC8, 10'h74, 10'h0, 3'h4, 1'h0, ST_IMM, AC_OVLD},
        '{15'h0, 15'h0, 15'h64, 10'h0, 10'h0, 10'hB, 3'h0, 1'h0, ST_DECEL, AC_ORUN},
        '{15'h0, 15'h0, 15'h0, 10'h0, 10'h0, 10'h0, 3'h4, 1'h1, ST_TRIP, AC_EXT}};

    svipq_top #(.SAMP0_CYC(4), .SAMP1_CYC(6), .SAMP2_CYC(8), .SAMP3_CYC(10), .MS_CYC(20))
        i_dut (.ref_clk, .rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cfgIn, .meas, .genIn, .alarmResetIn,
        .pulseInhibitIn, .errClearIn, .cmdPulseIn, .prot, .errClear, .pulseCount, .genLevel);
    svipq_host i_host (.ref_clk, .genIn, .alarmResetIn, .pulseInhibitIn, .errClearIn,
        .cmdPulseIn);

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            nErrors++;
            $display("Error at %0t ns: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        if (nErrors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int t);
        repeat (t) @(posedge ref_clk);
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'h0) break;
        end
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (i == 20) begin
            nErrors++;
            finish_test();
        end
    endtask
    // settings are only captured as reset releases, so each case resets
    task automatic start(input svipq_cfg_t s);
        cfgIn <= s;
        meas <= mb;
        rst <= 1'h1;
        tick(10);
        rst <= 1'h0;
        tick(2);
    endtask
    task automatic waitState(input svipq_state_t s, input int lim);
        int i;
        for (i = 0; i < lim && prot.state !== s; i++) tick(1);
        chk(prot.state, s);
        if (i == lim) finish_test();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} =
            {3'h4, 4'h0, 32'h0, 4'hF};
        base = '0;
        base.overrunLimit = 10'h00A;
        base.errCountClearMode = 3'h3;
        base.pulseInhibitEnable = 1'h1;
        base.alarmDetectAllowTime = 11'h003;
        mb = '0;
        mb.maxSpeed = 15'h03E8;
        mb.normTorque = 10'h064;
        cfgIn = base;
        meas = mb;
        tick(10);
        chk(prot, 32'h0);
        chk({pulseCount, genLevel, errClear}, 32'h0);
        start(base);
        bus(1'h0, 4'h0, 32'h0);
        chk(q, 32'h0);
        foreach (rows[k]) begin
            r = rows[k];
            c = base;
            {c.overspeedLevel, c.immStopOverspeedLevel, c.overloadLevel} = {r.osl, r.iso, r.ovl};
            c.alarmStopSel = r.sel;
            start(c);
            m = mb;
            {m.speed, m.torque, m.travel, m.extNoImm} = {r.spd, r.trq, r.trv, r.nim};
            meas <= m;
            tick(3);
            chk({prot.state, prot.alarmCode}, {r.st, r.ac});
        end
        // software alarm reset out of the last trip
        meas <= mb;
        bus(1'h1, 4'h8, 32'h2);
        tick(2);
        chk(prot.state, ST_RUN);
        // k = 4 picks stop selections that keep the normal limit
        for (k = 0; k < 5; k++) begin
            c = base;
            {c.driveProhibitStopSel, c.servoOffStopSel, c.mainPowerOffStopSel} =
                (k == 4) ? 12'h134 : 12'h289;
            c.immStopTorque = (k == 3) ? 10'h0 : 10'h32;
            start(c);
            m = mb;
            {m.dpDecel, m.soDecel, m.mpDecel} = 3'h4 >> (k % 3);
            meas <= m;
            tick(3);
            chk({prot.immTorqueActive, prot.torqueLimit},
                {k != 4, (k >= 3) ? 14'h3E8 : 14'h32});
        end
        bus(1'h0, 4'hC, 32'h0);
        chk(q, 32'h3E8);
        // detect time 3 ms at 20 cycles a tick: trip lands between 42 and 61 cycles
        c = base;
        c.alarmStopSel = 3'h4;
        start(c);
        m = mb;
        {m.speed, m.extImm} = {15'h64, 1'h1};
        meas <= m;
        tick(35);
        chk(prot.state, ST_IMM);
        waitState(ST_TRIP, 40);
        m.extImm = 1'h0;
        meas <= m;
        i_host.alarmResetIn <= 1'h1;
        tick(2300);
        chk(prot.state, ST_TRIP);
        waitState(ST_RUN, 300);
        i_host.alarmResetIn <= 1'h0;
        c.alarmResetConfirmSel = 1'h1;
        start(c);
        m.extImm = 1'h1;
        meas <= m;
        tick(5);
        m.extNoImm = 1'h1;
        meas <= m;
        tick(3);
        chk(prot.state, ST_TRIP);
        bus(1'h0, 4'h0, 32'h0);
        chk(q, 32'h54);
        meas <= mb;
        i_host.alarmResetIn <= 1'h1;
        tick(5);
        chk(prot.state, ST_TRIP);
        waitState(ST_RUN, 60);
        i_host.alarmResetIn <= 1'h0;
        for (k = 0; k < 4; k++) begin
            c = base;
            c.inputSamplePeriodSel = k[1:0];
            i_host.genIn <= 4'h0;
            start(c);
            i_host.genIn <= 4'h9 ^ k[3:0];
            for (n = 0; n < 80 && genLevel !== (4'h9 ^ k[3:0]); n++) tick(1);
            chk(n > 2 * (4 + 2 * k) && n <= 3 * (4 + 2 * k) + 3, 1'h1);
        end
        for (k = 0; k < 5; k++) begin
            c = base;
            c.errCountClearMode = k[2:0];
            start(c);
            n = 0;
            fork
                i_host.clearHold(hold[k]);
                repeat (hold[k] + 10) begin
                    @(posedge ref_clk);
                    n += (errClear === 1'h1);
                end
            join
            chk(n >= lo[k] && n <= hi[k], 1'h1);
        end
        c = base;
        c.pulseInhibitEnable = 1'h0;
        i_host.pulseInhibitIn <= 1'h1;
        start(c);
        tick(30);
        i_host.pulses(3);
        tick(4);
        chk(pulseCount, 16'h0);
        i_host.pulseInhibitIn <= 1'h0;
        tick(30);
        i_host.pulses(3);
        tick(4);
        chk(pulseCount, 16'h3);
        bus(1'h0, 4'h4, 32'h0);
        chk(q, 32'h3);
        // a write without its low byte lane must leave the count alone
        avs_byteenable <= 4'hE;
        bus(1'h1, 4'h8, 32'h1);
        bus(1'h0, 4'h4, 32'h0);
        chk(q, 32'h3);
        avs_byteenable <= 4'hF;
        bus(1'h1, 4'h8, 32'h1);
        bus(1'h0, 4'h4, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, 4'h8, 32'h0);
        chk(q, 32'h0);
        i_host.pulseInhibitIn <= 1'h1;
        start(base);
        tick(30);
        i_host.pulses(2);
        tick(4);
        chk(pulseCount, 16'h2);
        finish_test();
    end
endmodule // test_svipq_top
